/* File: logic/teil_core.sv */
// Purpose: Software trap pending logic, vector arbitration and port
//          edge interrupts with wakeup
// Assumes: Core gives one-cycle strobes for fetch, pop, vector select,
//          pending clear, returns and interrupt take
// Notes:   Trap pending flag has no address; it only leaves as a port
//          toward the core
//
// Behaviour
// [RL1] One hidden trap-pending flag, no address
// [RL2] Reset clears the trap-pending flag
// [RL3] Trap occurrence sets the flag to one
// [RL4] Clear instruction always clears; only other means (here a trap in the same cycle wins and keeps the flag set)
// [RL5] Fetched zero opcode raises software trap
// [RL6] Unmapped fetches return zero data
// [RL7] Pop past stack limit loads 7FFF
// [RL8] Trap highest priority, acknowledged immediately
// [RL9] Trap leaves global enable unchanged
// [RL10] Pending trap blocks others; vector to trap
// [RL11] Trap routine preempted only by traps
// [RL12] Trap pushes address of trapping opcode
// [RL13] Software clears flag then skip-returns
// [RL14] Eight port edge interrupts, one vector
// [RL15] Per-pin enable register
// [RL16] Per-pin rising or falling edge select
// [RL17] Edges latch into per-pin pending register
// [RL18] Group enable gates all port interrupts
// [RL19] Global enable gates interrupts overall
// [RL20] Wake without interrupt resumes next instruction
// [RL21] Wake with interrupt runs service first
// [RL22] Maskable never preempts running routine
// [RL23] Vector select writes even low byte
// [RL24] Port vector E2, trap vector FE
// [RL25] Port request needs pending, enables, global

// ==========================================================
// Top module
module teil_core
  import teil_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Program fetch from memory
  input  wire logic                  fetch_stb,
  input  wire logic                  fetch_hit,
  input  wire logic [7:0]            fetch_data,
  input  wire logic [14:0]           fetch_pc,
  // Stack pop
  input  wire logic                  pop_stb,
  input  wire logic [7:0]            pop_sp,
  // Instruction strobes from the core
  input  wire logic                  clr_pend_stb,
  input  wire logic                  vis_stb,
  input  wire logic                  ret_stb,
  input  wire logic                  int_take,
  input  wire logic                  gie_wr,
  input  wire logic                  gie_val,
  // Port interrupt configuration
  input  wire logic                  en_wr,
  input  wire logic [7:0]            en_val,
  input  wire logic                  edg_wr,
  input  wire logic [7:0]            edg_val,
  input  wire logic                  grp_wr,
  input  wire logic                  grp_val,
  input  wire logic [7:0]            pnd_clr,
  // Pins, peripherals and power state
  input  wire logic [7:0]            port_pin,
  input  wire logic [NUM_PERIPH-1:0] periph_req,
  input  wire logic                  low_power,
  // Toward the core
  output logic      [7:0]            ir_data_ff,
  output logic                       ir_valid_ff,
  output logic                       trap_ack_ff,
  output logic      [14:0]           trap_ret_addr_ff,
  output logic                       trap_pending_flag_ff,
  output logic                       pc_load_ff,
  output logic      [14:0]           pc_load_addr_ff,
  output logic                       int_req,
  output logic                       vis_done_ff,
  output logic      [7:0]            vis_low_ff,
  // Status
  output logic                       global_int_enable_ff,
  output logic      [7:0]            port_wake_enable_reg_ff,
  output logic      [7:0]            port_wake_edge_reg_ff,
  output logic      [7:0]            port_wake_pending_reg_ff,
  output logic                       port_int_group_enable_ff,
  output logic                       port_int_req,
  output logic                       wake_ff,
  output logic                       wake_isr_ff
);

  // ========================================================
  // Declarations
  function automatic logic [7:0] vec_low(input logic [3:0] idx);
    vec_low = VEC_BASE + {3'b000, idx, 1'b0};
  endfunction : vec_low

  logic [7:0]            edge_hit;
  logic [7:0]            fetched;
  logic                  trap_hit;
  logic                  port_act;
  logic [NUM_PERIPH+1:0] rank_req;
  logic [3:0]            win_idx;
  teil_ctx_t             ctx_ff;
  teil_ctx_t             nxt_ctx;
  logic [7:0]            nxt_ir;
  logic                  nxt_ir_valid;
  logic                  nxt_ack;
  logic [14:0]           nxt_ret;
  logic                  nxt_pend;
  logic                  nxt_pc_load;
  logic [14:0]           nxt_pc_addr;
  logic                  nxt_vis_done;
  logic [7:0]            nxt_vis_low;
  logic                  nxt_gie;
  logic [7:0]            nxt_en;
  logic [7:0]            nxt_edg;
  logic [7:0]            nxt_pnd;
  logic                  nxt_grp;
  logic                  nxt_wake;
  logic                  nxt_wake_isr;

  // ========================================================
  // Port edge detection
  teil_edge_det u_teil_edge_det
  (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .port_pin (port_pin),
    .edge_sel (port_wake_edge_reg_ff),
    .edge_hit (edge_hit)
  );

  // ========================================================
  // Request and arbitration terms
  // Unmapped locations read back as zero opcode
  assign fetched  = fetch_hit ? fetch_data : RST_BYTE; // see [RL6]
  assign trap_hit = fetch_stb && (fetched == TRAP_OPCODE); // see [RL5]
  // Any enabled pending port bit under group enable
  assign port_act = |(port_wake_pending_reg_ff & port_wake_enable_reg_ff)
                    && port_int_group_enable_ff; // see [RL18]
  assign port_int_req = port_act && global_int_enable_ff; // see [RL25]
  assign rank_req = {periph_req, port_act, 1'b0}; // see [RL14]

  // Maskable request blocked by pending trap or open routine
  assign int_req = !trap_pending_flag_ff && (ctx_ff == CTX_MAIN)
                   && global_int_enable_ff
                   && (|rank_req); // see [RL10] [RL19] [RL22]

  // Highest ranked active source, trap above all
  always_comb
  begin
    win_idx = IDX_DEFAULT;
    for (int i = 1; i <= NUM_PERIPH + 1; i++)
    begin
      if (rank_req[i])
      begin
        win_idx = 4'(i);
      end
    end
    if (trap_pending_flag_ff)
    begin
      win_idx = IDX_TRAP; // see [RL8] [RL10]
    end
  end

  // ========================================================
  // Trap, fetch and vector next state
  always_comb
  begin
    nxt_ir       = ir_data_ff;
    nxt_ir_valid = fetch_stb;
    nxt_ack      = trap_hit; // see [RL8]
    nxt_ret      = trap_ret_addr_ff;
    nxt_pc_load  = 1'b0;
    nxt_pc_addr  = pc_load_addr_ff;
    nxt_vis_done = vis_stb;
    nxt_vis_low  = vis_low_ff;
    if (fetch_stb)
    begin
      nxt_ir = fetched;
    end
    if (trap_hit)
    begin
      nxt_ret = fetch_pc; // see [RL12]
    end
    // Set wins over the clear instruction
    nxt_pend = trap_hit
               || (trap_pending_flag_ff && !clr_pend_stb); // see [RL3] [RL4]
    if (pop_stb && (pop_sp > STACK_LIMIT))
    begin
      nxt_pc_load = 1'b1; // see [RL7]
      nxt_pc_addr = PC_UNDERFLOW;
    end
    if (vis_stb)
    begin
      nxt_vis_low = vec_low(win_idx); // see [RL23] [RL24]
    end
  end

  // Service context and global enable
  always_comb
  begin
    nxt_ctx = ctx_ff;
    nxt_gie = global_int_enable_ff;
    case (ctx_ff)
      CTX_MAIN:
      begin
        if (int_take)
        begin
          nxt_ctx = CTX_MASK;
        end
      end
      CTX_MASK:
      begin
        if (ret_stb)
        begin
          nxt_ctx = CTX_MAIN;
        end
      end
      CTX_TRAP:
      begin
        if (ret_stb)
        begin
          nxt_ctx = CTX_MAIN;
        end
      end
      default:
      begin
        nxt_ctx = CTX_MAIN;
      end
    endcase
    // Trap preempts any context; maskables never do
    if (trap_hit)
    begin
      nxt_ctx = CTX_TRAP; // see [RL11] [RL22]
    end
    if (gie_wr)
    begin
      nxt_gie = gie_val;
    end
    // Taking a maskable closes the gate; a trap leaves it
    if (int_take)
    begin
      nxt_gie = 1'b0; // see [RL9]
    end
  end

  // Port registers and wakeup
  always_comb
  begin
    nxt_en  = en_wr  ? en_val  : port_wake_enable_reg_ff; // see [RL15]
    nxt_edg = edg_wr ? edg_val : port_wake_edge_reg_ff; // see [RL16]
    nxt_grp = grp_wr ? grp_val : port_int_group_enable_ff;
    // Edge set wins over software clear
    nxt_pnd = edge_hit
              | (port_wake_pending_reg_ff & ~pnd_clr); // see [RL17]
    nxt_wake = low_power
               && (|(port_wake_pending_reg_ff & port_wake_enable_reg_ff));
    nxt_wake_isr = nxt_wake && port_int_req; // see [RL20] [RL21]
  end

  // ========================================================
  // Registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ir_data_ff               <= RST_BYTE;
      ir_valid_ff              <= 1'b0;
      trap_ack_ff              <= 1'b0;
      trap_ret_addr_ff         <= RST_ADDR;
      trap_pending_flag_ff     <= 1'b0; // see [RL2]
      pc_load_ff               <= 1'b0;
      pc_load_addr_ff          <= RST_ADDR;
      vis_done_ff              <= 1'b0;
      vis_low_ff               <= RST_BYTE;
      ctx_ff                   <= CTX_MAIN;
      global_int_enable_ff     <= 1'b0;
      port_wake_enable_reg_ff  <= RST_BYTE;
      port_wake_edge_reg_ff    <= RST_BYTE;
      port_wake_pending_reg_ff <= RST_BYTE;
      port_int_group_enable_ff <= 1'b0;
      wake_ff                  <= 1'b0;
      wake_isr_ff              <= 1'b0;
    end
    else
    begin
      ir_data_ff               <= nxt_ir;
      ir_valid_ff              <= nxt_ir_valid;
      trap_ack_ff              <= nxt_ack;
      trap_ret_addr_ff         <= nxt_ret;
      trap_pending_flag_ff     <= nxt_pend; // see [RL1]
      pc_load_ff               <= nxt_pc_load;
      pc_load_addr_ff          <= nxt_pc_addr;
      vis_done_ff              <= nxt_vis_done;
      vis_low_ff               <= nxt_vis_low;
      ctx_ff                   <= nxt_ctx;
      global_int_enable_ff     <= nxt_gie;
      port_wake_enable_reg_ff  <= nxt_en;
      port_wake_edge_reg_ff    <= nxt_edg;
      port_wake_pending_reg_ff <= nxt_pnd;
      port_int_group_enable_ff <= nxt_grp;
      wake_ff                  <= nxt_wake;
      wake_isr_ff              <= nxt_wake_isr;
    end
  end

  // ========================================================
  // Assertions
  property p_trap_set;
    @(posedge clk_sys) disable iff (rst)
    (fetch_stb && fetch_hit && fetch_data == 8'h00)
      |=> (trap_pending_flag_ff && trap_ack_ff);
  endproperty
  a_trap_set: assert property (p_trap_set) // see [RL3] [RL5] [RL8]
    else $error("zero opcode did not raise trap");

  property p_unmapped_zero;
    @(posedge clk_sys) disable iff (rst)
    (fetch_stb && !fetch_hit)
      |=> (ir_data_ff == 8'h00) && trap_pending_flag_ff;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) // see [RL6]
    else $error("unmapped fetch not zero");

  property p_clear;
    @(posedge clk_sys) disable iff (rst)
    (clr_pend_stb && !trap_hit) |=> !trap_pending_flag_ff;
  endproperty
  a_clear: assert property (p_clear) // see [RL4]
    else $error("clear instruction left flag set");

  property p_hold;
    @(posedge clk_sys) disable iff (rst)
    (trap_pending_flag_ff && !clr_pend_stb) |=> trap_pending_flag_ff;
  endproperty
  a_hold: assert property (p_hold) // see [RL4]
    else $error("flag cleared without clear instruction");

  property p_underflow;
    @(posedge clk_sys) disable iff (rst)
    (pop_stb && pop_sp > 8'h6F)
      |=> pc_load_ff && (pc_load_addr_ff == 15'h7FFF);
  endproperty
  a_underflow: assert property (p_underflow) // see [RL7]
    else $error("stack underflow did not load 7FFF");

  property p_block;
    @(posedge clk_sys) disable iff (rst)
    trap_pending_flag_ff |-> !int_req;
  endproperty
  a_block: assert property (p_block) // see [RL10]
    else $error("maskable request during pending trap");

  property p_vis_trap;
    @(posedge clk_sys) disable iff (rst)
    (vis_stb && trap_pending_flag_ff)
      |=> vis_done_ff && (vis_low_ff == 8'hFE);
  endproperty
  a_vis_trap: assert property (p_vis_trap) // see [RL23] [RL24]
    else $error("vector select missed trap vector");

  property p_vis_port;
    @(posedge clk_sys) disable iff (rst)
    (vis_stb && !trap_pending_flag_ff && periph_req == '0 && port_act)
      |=> (vis_low_ff == 8'hE2);
  endproperty
  a_vis_port: assert property (p_vis_port) // see [RL24]
    else $error("port vector not E2");

  property p_gie_kept;
    @(posedge clk_sys) disable iff (rst)
    (trap_hit && !gie_wr && !int_take) |=> $stable(global_int_enable_ff);
  endproperty
  a_gie_kept: assert property (p_gie_kept) // see [RL9]
    else $error("trap changed global enable");

  property p_ret_addr;
    @(posedge clk_sys) disable iff (rst)
    trap_hit |=> (trap_ret_addr_ff == $past(fetch_pc));
  endproperty
  a_ret_addr: assert property (p_ret_addr) // see [RL12]
    else $error("trap return address wrong");

  property p_edge_latch;
    @(posedge clk_sys) disable iff (rst)
    (edge_hit != 8'h00)
      |=> ((port_wake_pending_reg_ff & $past(edge_hit))
           == $past(edge_hit));
  endproperty
  a_edge_latch: assert property (p_edge_latch) // see [RL17]
    else $error("edge not latched as pending");

endmodule : teil_core

/* File: logic/teil_edge_det.sv */
// Purpose: Synchronise eight port pins and flag the selected edge
// Assumes: Pins are asynchronous to clk_sys
// Notes:   Edge select 1 picks falling, 0 picks rising

// ==========================================================
// Edge detector
module teil_edge_det
  import teil_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Pins and trigger select
  input  wire logic [7:0] port_pin,
  input  wire logic [7:0] edge_sel,
  // One-cycle edge hits
  output logic      [7:0] edge_hit
);

  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic [7:0] prev_ff;
  logic [7:0] nxt_sync1;
  logic [7:0] nxt_sync2;
  logic [7:0] nxt_prev;

  // Next values of the synchroniser chain
  always_comb
  begin
    nxt_sync1 = port_pin;
    nxt_sync2 = sync1_ff;
    nxt_prev  = sync2_ff;
  end

  // Synchroniser and history registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync1_ff <= RST_BYTE;
      sync2_ff <= RST_BYTE;
      prev_ff  <= RST_BYTE;
    end
    else
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff  <= nxt_prev;
    end
  end

  // Rising or falling edge per pin
  assign edge_hit = (edge_sel & ~sync2_ff & prev_ff)
                  | (~edge_sel & sync2_ff & ~prev_ff); // see [RL16]

endmodule : teil_edge_det

/* File: logic/teil_pkg.sv */
// Purpose: Shared constants for the trap and port edge interrupt logic
// Assumes: One clock, asynchronous active-high reset
// Notes:   Vector low bytes are even values from the base upward

// ==========================================================
// Package
package teil_pkg;

  // Opcode and memory constants
  localparam logic [7:0]  TRAP_OPCODE  = 8'h00;
  localparam logic [7:0]  STACK_LIMIT  = 8'h6F;
  localparam logic [14:0] PC_UNDERFLOW = 15'h7FFF;

  // Vector block layout
  localparam logic [7:0]  VEC_BASE     = 8'hE0;
  localparam logic [3:0]  IDX_DEFAULT  = 4'h0;
  localparam logic [3:0]  IDX_PORT     = 4'h1;
  localparam logic [3:0]  IDX_TRAP     = 4'hF;
  localparam int          NUM_PERIPH   = 13;

  // Values after reset
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [14:0] RST_ADDR     = 15'h0000;

  // Service context, Gray coded along main-mask-trap
  typedef enum logic [1:0]
  {
    CTX_MAIN = 2'b00,
    CTX_MASK = 2'b01,
    CTX_TRAP = 2'b11
  } teil_ctx_t;

endpackage : teil_pkg

/* File: verif/teil_mem_model.sv */
// Purpose: Program memory model that answers fetches from the trap logic
// Assumes: Locations below MEM_TOP are programmed, others do not exist
// Notes:   Programmed bytes are never zero except one planted trap
//          opcode at TRAP_AT; absent locations float

// ==========================================================
// Memory model
module teil_mem_model #(
  parameter logic [14:0] MEM_TOP = 15'h2000,
  parameter logic [14:0] TRAP_AT = 15'h0100
)
(
  // Clock
  input  wire logic        clk_sys,
  // Fetch address and answer
  input  wire logic [14:0] fetch_pc,
  output logic             fetch_hit,
  output logic      [7:0]  fetch_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] junk_ff = 8'h3C;

  // Floating data bus wanders every cycle
  always @(posedge clk_sys)
  begin
    junk_ff <= junk_ff + 8'h5B;
  end

  // Programmed bytes carry the low address bits with the top bit set
  always_comb
  begin
    fetch_hit  = (fetch_pc < MEM_TOP);
    fetch_data = fetch_hit ? {1'b1, fetch_pc[6:0]} : junk_ff;
    if (fetch_pc == TRAP_AT)
    begin
      fetch_data = 8'h00; // Planted trap opcode
    end
  end
endmodule : teil_mem_model

/* File: verif/test_teil_core.sv */
// Purpose: Self-checking bench for the trap and port edge interrupt logic
// Assumes: Inputs change 1 ns after the rising edge of clk_sys
// Notes:   Random port patterns come from a fixed seed

// ==========================================================
// Testbench top
module test_teil_core
  import teil_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys, rst, fetch_stb, fetch_hit, pop_stb;
  logic        clr_pend_stb, vis_stb, ret_stb, int_take, low_power;
  logic        gie_wr, gie_val, en_wr, edg_wr, grp_wr, grp_val;
  logic [7:0]  fetch_data, pop_sp, en_val, edg_val, pnd_clr, port_pin;
  logic [14:0] fetch_pc;
  logic [12:0] periph_req;
  logic [7:0]  ir_data_ff, vis_low_ff, exp_pnd, exp_low;
  logic        ir_valid_ff, trap_ack_ff, trap_pending_flag_ff, pc_load_ff;
  logic        int_req, vis_done_ff, global_int_enable_ff, port_int_req;
  logic        port_int_group_enable_ff, wake_ff, wake_isr_ff;
  logic [14:0] trap_ret_addr_ff, pc_load_addr_ff;
  logic [7:0]  port_wake_enable_reg_ff, port_wake_edge_reg_ff;
  logic [7:0]  port_wake_pending_reg_ff;
  int          seed, mismatches, samples_checked;
  logic [7:0]  sp_tab [3];

  // Design under test and memory partner
  teil_core u_teil_core (
    .clk_sys, .rst, .fetch_stb, .fetch_hit, .fetch_data, .fetch_pc,
    .pop_stb, .pop_sp, .clr_pend_stb, .vis_stb, .ret_stb, .int_take,
    .gie_wr, .gie_val, .en_wr, .en_val, .edg_wr, .edg_val, .grp_wr,
    .grp_val, .pnd_clr, .port_pin, .periph_req, .low_power, .ir_data_ff,
    .ir_valid_ff, .trap_ack_ff, .trap_ret_addr_ff, .trap_pending_flag_ff,
    .pc_load_ff, .pc_load_addr_ff, .int_req, .vis_done_ff, .vis_low_ff,
    .global_int_enable_ff, .port_wake_enable_reg_ff, .port_wake_edge_reg_ff,
    .port_wake_pending_reg_ff, .port_int_group_enable_ff, .port_int_req,
    .wake_ff, .wake_isr_ff);
  teil_mem_model u_teil_mem_model (.clk_sys, .fetch_pc, .fetch_hit,
    .fetch_data);

  // ========================================================
  // Helpers
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // One clock, then settle past the edge
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic fetch(input logic [14:0] pc);
    fetch_pc  = pc;
    fetch_stb = 1'b1;
    tick();
    fetch_stb = 1'b0;
  endtask : fetch

  task automatic cfg_gie_grp(input logic global_int_enable, input logic grp);
    gie_val = global_int_enable;
    grp_val = grp;
    gie_wr  = 1'b1;
    grp_wr  = 1'b1;
    tick();
    gie_wr  = 1'b0;
    grp_wr  = 1'b0;
  endtask : cfg_gie_grp

  // Configure, settle pins, clear pending, then move pins
  task automatic port_round(input logic [7:0] en, edg, p0, p1);
    en_val   = en;
    edg_val  = edg;
    en_wr    = 1'b1;
    edg_wr   = 1'b1;
    port_pin = p0;
    tick();
    en_wr    = 1'b0;
    edg_wr   = 1'b0;
    repeat (5) tick();
    pnd_clr  = 8'hFF;
    tick();
    pnd_clr  = 8'h00;
    port_pin = p1;
    repeat (5) tick();
    exp_pnd  = (edg & p0 & ~p1) | (~edg & ~p0 & p1);
    chk("pending", 16'(port_wake_pending_reg_ff), 16'(exp_pnd));
    chk("enable", 16'(port_wake_enable_reg_ff), 16'(en));
    chk("edge_sel", 16'(port_wake_edge_reg_ff), 16'(edg));
  endtask : port_round

  // Expected new low byte of the program counter
  function automatic logic [7:0] exp_vis(input logic flag,
                                         input logic [12:0] per,
                                         input logic port_act);
    exp_vis = port_act ? 8'hE2 : 8'hE0;
    for (int k = 0; k < 13; k++)
      if (per[k])
        exp_vis = 8'hE0 + 8'(2 * (k + 2));
    if (flag)
      exp_vis = 8'hFE;
  endfunction : exp_vis

  // ========================================================
  // Clock and hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    final_report();
  end

  // ========================================================
  // Main sequence
  initial
  begin
    seed = 86311;
    {rst, fetch_stb, pop_stb, clr_pend_stb, vis_stb, ret_stb} = 6'h20;
    {int_take, low_power, gie_wr, gie_val, en_wr, edg_wr} = 6'h00;
    {grp_wr, grp_val} = 2'b00;
    {pop_sp, en_val, edg_val, pnd_clr, port_pin} = 40'h0;
    fetch_pc   = 15'h0000;
    periph_req = 13'h0000;
    sp_tab     = '{8'h70, 8'h6F, 8'hFF};
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk("flag_rst", 16'(trap_pending_flag_ff), 16'h0000);
    // Programmed byte passes through without a trap
    fetch(15'h0123);
    chk("ir_valid", 16'(ir_valid_ff), 16'h0001);
    chk("ir_data", 16'(ir_data_ff), 16'h00A3);
    chk("no_ack", 16'(trap_ack_ff), 16'h0000);
    // Planted zero opcode traps, then clear and skip-return
    fetch(15'h0100);
    chk("op_ack", 16'(trap_ack_ff), 16'h0001);
    chk("op_flag", 16'(trap_pending_flag_ff), 16'h0001);
    chk("op_addr", 16'(trap_ret_addr_ff), 16'h0100);
    clr_pend_stb = 1'b1;
    ret_stb      = 1'b1;
    tick();
    clr_pend_stb = 1'b0;
    ret_stb      = 1'b0;
    chk("op_clr", 16'(trap_pending_flag_ff), 16'h0000);
    // Stack pop boundary and random pointers
    for (int i = 0; i < 6; i++)
    begin
      pop_sp  = (i < 3) ? sp_tab[i] : 8'($random(seed));
      pop_stb = 1'b1;
      tick();
      pop_stb = 1'b0;
      chk("pc_load", 16'(pc_load_ff), 16'(pop_sp > 8'h6F));
      if (pop_sp > 8'h6F)
        chk("pc_addr", 16'(pc_load_addr_ff), 16'h7FFF);
    end
    // Port edges, random then fixed corner
    for (int i = 0; i < 4; i++)
      port_round(8'($random(seed)), 8'($random(seed)),
                 8'($random(seed)), 8'($random(seed)));
    port_round(8'h81, 8'h80, 8'h80, 8'h01);
    // Group and global enable combinations
    for (int i = 0; i < 4; i++)
    begin
      cfg_gie_grp(i[1], i[0]);
      chk("grp", 16'(port_int_group_enable_ff), 16'(i[0]));
      chk("port_req", 16'(port_int_req), 16'(i[0] & i[1]));
      chk("int_req", 16'(int_req), 16'(i[0] & i[1]));
    end
    // Wake from low power with and without interrupt
    low_power = 1'b1;
    repeat (2) tick();
    chk("wake", 16'(wake_ff), 16'h0001);
    chk("wake_isr", 16'(wake_isr_ff), 16'h0001);
    cfg_gie_grp(1'b0, 1'b1);
    tick();
    chk("wake_noisr", 16'(wake_isr_ff), 16'h0000);
    low_power = 1'b0;
    // Vector selection among random peripheral requests
    for (int i = 0; i < 8; i++)
    begin
      periph_req = (i == 0) ? 13'h0000 : 13'($random(seed));
      vis_stb    = 1'b1;
      tick();
      vis_stb    = 1'b0;
      exp_low    = exp_vis(1'b0, periph_req, 1'b1);
      chk("vis_done", 16'(vis_done_ff), 16'h0001);
      chk("vis_low", 16'(vis_low_ff), 16'(exp_low));
    end
    chk("wake_off", 16'(wake_ff), 16'h0000);
    periph_req = 13'h0000;
    cfg_gie_grp(1'b1, 1'b1);
    chk("int_req_on", 16'(int_req), 16'h0001);
    // Running maskable routine is not preempted
    int_take = 1'b1;
    tick();
    int_take = 1'b0;
    cfg_gie_grp(1'b1, 1'b1);
    chk("no_nest", 16'(int_req), 16'h0000);
    // Trap inside the maskable routine
    fetch(15'h7FFF);
    chk("trap_ack", 16'(trap_ack_ff), 16'h0001);
    chk("trap_flag", 16'(trap_pending_flag_ff), 16'h0001);
    chk("ret_addr", 16'(trap_ret_addr_ff), 16'h7FFF);
    chk("zero_data", 16'(ir_data_ff), 16'h0000);
    chk("gie_kept", 16'(global_int_enable_ff), 16'h0001);
    ret_stb = 1'b1;
    tick();
    ret_stb = 1'b0;
    chk("ack_pulse", 16'(trap_ack_ff), 16'h0000);
    chk("blocked", 16'(int_req), 16'h0000);
    vis_stb = 1'b1;
    tick();
    vis_stb = 1'b0;
    chk("vis_trap", 16'(vis_low_ff), 16'h00FE);
    // Clear meeting a new trap keeps the flag, clear alone drops it
    clr_pend_stb = 1'b1;
    fetch(15'h4000);
    chk("clr_vs_trap", 16'(trap_pending_flag_ff), 16'h0001);
    tick();
    clr_pend_stb = 1'b0;
    chk("clr_alone", 16'(trap_pending_flag_ff), 16'h0000);
    ret_stb = 1'b1;
    tick();
    ret_stb = 1'b0;
    chk("resume", 16'(int_req), 16'h0001);
    // Reset in mid-run drops a set flag and the global enable
    fetch(15'h5000);
    rst = 1'b1;
    tick();
    chk("flag_rst2", 16'(trap_pending_flag_ff), 16'h0000);
    chk("gie_rst2", 16'(global_int_enable_ff), 16'h0000);
    rst = 1'b0;
    // Trap works again right after release
    fetch(15'h6000);
    chk("flag_again", 16'(trap_pending_flag_ff), 16'h0001);
    final_report();
  end
endmodule : test_teil_core
